// ---- csa_defines.svh ----
`ifndef CSA_DEFINES_SVH
`define CSA_DEFINES_SVH
// File addresses of the special registers.
`define CSA_IDX_WINDOW 5'h00
`define CSA_IDX_PC_LOW 5'h02
`define CSA_IDX_FLAGS 5'h03
`define CSA_IDX_POINTER 5'h04
`define CSA_IDX_RAM_FIRST 5'h05
// Bus word index of the full program counter readback.
`define CSA_IDX_PC_FULL 6'h20
// Bit positions inside core_flags.
`define CSA_BIT_WAKE 7
`define CSA_BIT_PAGE 5
`define CSA_BIT_EXPIRY 4
`define CSA_BIT_SLEEP 3
`define CSA_BIT_ZERO 2
`define CSA_BIT_NIBBLE 1
`define CSA_BIT_CARRY 0
// Reset values.
`define CSA_FLAGS_RESET 8'h18
`define CSA_POINTER_RESET 6'h00
`define CSA_RESET_VECTOR 12'h000
// Program memory geometry.
`define CSA_PC_WIDTH 12
`define CSA_PAGE_WORDS 512
`define CSA_SMALL_WORDS 512
`define CSA_LARGE_WORDS 1024
`endif

// ---- csa_pkg.sv ----
package csa_pkg;
   typedef enum logic [2:0] {
      CSA_OP_MOVE, CSA_OP_LOGIC, CSA_OP_ADD, CSA_OP_SUB, CSA_OP_RRF, CSA_OP_RLF
   } csa_alu_op_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic [4:0] fsel;
      csa_alu_op_t op;
      logic [7:0] operand;
      logic [7:0] wdata;
      logic pc_inc;
      logic pc_load;
      logic [8:0] pc_target;
   } csa_core_req_t;
   typedef struct packed {
      logic [7:0] result;
      logic [7:0] file_value;
      logic [7:0] flags;
   } csa_core_resp_t;
endpackage : csa_pkg

// ---- csa_file_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
module csa_file_ram #(
   parameter int AW = 5
) (
   // Clock.
   input wire logic clk,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   // Read port.
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   initial begin
      if (AW < 5 || AW > 6) $error("csa_file_ram: AW must be 5 or 6.");
   end
   logic [7:0] mem_reg [2**AW];
   assign rdata = mem_reg[raddr];
   always_ff @(posedge clk) begin
      if (we) mem_reg[waddr] <= wdata;
   end
endmodule : csa_file_ram
`default_nettype wire

// ---- csa_ahb_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module csa_ahb_port (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Access towards the register file.
   input wire logic core_busy,
   input wire logic [31:0] rd_value,
   output logic acc_wr,
   output logic acc_rd,
   output logic [5:0] acc_idx,
   output logic [7:0] acc_wdata
);
   logic pend_reg;
   logic write_reg;
   logic mapped_reg;
   logic [5:0] idx_reg;
   logic ready_reg;
   logic [31:0] rdata_reg;
   wire take = hsel & htrans[1] & hready;
   wire done = pend_reg & ~core_busy;
   assign acc_wr = done & write_reg & mapped_reg;
   assign acc_rd = done & ~write_reg & mapped_reg;
   assign acc_idx = idx_reg;
   assign acc_wdata = hwdata[7:0];
   assign hreadyout = ready_reg;
   assign hrdata = rdata_reg;
   assign hresp = 1'b0;
   always_ff @(posedge clk) begin
      if (reset) begin
         pend_reg <= 1'b0;
         ready_reg <= 1'b1;
         write_reg <= 1'b0;
         mapped_reg <= 1'b0;
         idx_reg <= 6'h00;
         rdata_reg <= 32'h0000_0000;
      end else if (take) begin
         pend_reg <= 1'b1;
         ready_reg <= 1'b0;
         write_reg <= hwrite;
         mapped_reg <= ~|haddr[31:8];
         idx_reg <= haddr[7:2];
      end else if (done) begin
         pend_reg <= 1'b0;
         ready_reg <= 1'b1;
         rdata_reg <= acc_rd ? rd_value : 32'h0000_0000;
      end
   end
endmodule : csa_ahb_port
`default_nettype wire

// ---- csa_core_status.sv ----
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "csa_defines.svh"
module csa_core_status
   import csa_pkg::*;
#(
   parameter bit LARGE = 1'b0,
   parameter int PROG_WORDS = LARGE ? `CSA_LARGE_WORDS : `CSA_SMALL_WORDS
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Instruction core.
   input wire csa_core_req_t core_req,
   output var csa_core_resp_t core_resp,
   output var logic [`CSA_PC_WIDTH-1:0] program_counter,
   // Reset cause and watchdog events.
   input wire logic wake_cause,
   input wire logic wdt_kick,
   input wire logic sleep_op,
   input wire logic wdt_timeout,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp
);
   localparam int RAW = LARGE ? 6 : 5;
   localparam logic [`CSA_PC_WIDTH-1:0] PC_MASK = `CSA_PC_WIDTH'(PROG_WORDS - 1);

   initial begin
      if (PROG_WORDS != `CSA_SMALL_WORDS && PROG_WORDS != `CSA_LARGE_WORDS) begin
         $error("csa_core_status: PROG_WORDS must be 512 or 1024.");
      end
      if (!LARGE && PROG_WORDS > `CSA_SMALL_WORDS) begin
         $error("csa_core_status: the small variant has no second page.");
      end
   end

   function automatic logic [9:0] csa_alu(input csa_alu_op_t op, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] w,
                                          input logic cin);
      logic [8:0] sum;
      logic [4:0] nib;
      sum = 9'h000;
      nib = 5'h00;
      case (op)
         CSA_OP_ADD: begin
            sum = {1'b0, a} + {1'b0, b};
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
         end
         CSA_OP_SUB: begin
            sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
            nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
         end
         default: begin
            sum = 9'h000;
            nib = 5'h00;
         end
      endcase
      case (op)
         CSA_OP_ADD, CSA_OP_SUB: csa_alu = {sum[8], nib[4], sum[7:0]};
         CSA_OP_RRF: csa_alu = {a[0], 1'b0, cin, a[7:1]};
         CSA_OP_RLF: csa_alu = {a[7], 1'b0, a[6:0], cin};
         default: csa_alu = {2'b00, w};
      endcase
   endfunction : csa_alu

   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [5:0] pointer_reg;
   logic [5:0] pointer_next;
   logic [`CSA_PC_WIDTH-1:0] pc_reg;
   logic [`CSA_PC_WIDTH-1:0] pc_next;
   logic [7:0] result_reg;
   logic [7:0] file_value_reg;

   // Bus port; the core always has priority and stalls the bus.
   wire logic ahb_wr;
   wire logic ahb_rd;
   wire logic [5:0] ahb_idx;
   wire logic [7:0] ahb_wdata;
   wire logic [31:0] ahb_value;

   csa_ahb_port u_port (
      .clk(clk),
      .reset(reset),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .core_busy(core_req.valid),
      .rd_value(ahb_value),
      .acc_wr(ahb_wr),
      .acc_rd(ahb_rd),
      .acc_idx(ahb_idx),
      .acc_wdata(ahb_wdata)
   );

   // Shared file access, from the core or else from the bus.
   wire logic sel_core = core_req.valid;
   wire logic [4:0] fsel = sel_core ? core_req.fsel : ahb_idx[4:0];
   wire logic bus_file = ~sel_core & ~ahb_idx[5];
   wire logic acc_wr = sel_core ? core_req.write : (ahb_wr & bus_file);
   wire logic bank_bit = LARGE & pointer_reg[5];
   wire logic is_ind = (fsel == `CSA_IDX_WINDOW);
   wire logic [4:0] eff_low = is_ind ? pointer_reg[4:0] : fsel;
   wire logic [5:0] eff_addr = {bank_bit, eff_low};
   wire logic ind_self = is_ind & (pointer_reg[4:0] == `CSA_IDX_WINDOW);
   wire logic tgt_flags = (eff_low == `CSA_IDX_FLAGS);
   wire logic tgt_pointer = (eff_low == `CSA_IDX_POINTER);
   wire logic tgt_special = (eff_low < `CSA_IDX_RAM_FIRST);

   // Pointer readback with the unimplemented upper bits as ones.
   wire logic [7:0] pointer_view = LARGE ? {2'b11, pointer_reg}
                                         : {3'b111, pointer_reg[4:0]};

   wire logic [7:0] ram_rdata;
   wire logic [7:0] file_rd = (eff_low == `CSA_IDX_WINDOW) ? 8'h00 :
                              (eff_low == `CSA_IDX_PC_LOW) ? pc_reg[7:0] :
                              tgt_flags ? flags_reg :
                              tgt_pointer ? pointer_view :
                              ram_rdata;

   // Result of the executing instruction.
   wire logic [9:0] alu_out = csa_alu(core_req.op, file_rd, core_req.operand,
                                      core_req.wdata, flags_reg[`CSA_BIT_CARRY]);
   wire logic [7:0] alu_res = alu_out[7:0];
   wire logic alu_c = alu_out[9];
   wire logic alu_dc = alu_out[8];
   wire logic [7:0] wr_data = sel_core ? alu_res : ahb_wdata;

   // Which flags the executing instruction owns.
   wire logic op_arith = (core_req.op == CSA_OP_ADD) | (core_req.op == CSA_OP_SUB);
   wire logic op_rot = (core_req.op == CSA_OP_RRF) | (core_req.op == CSA_OP_RLF);
   wire logic upd_z = sel_core & (op_arith | (core_req.op == CSA_OP_LOGIC));
   wire logic upd_dc = sel_core & op_arith;
   wire logic upd_c = sel_core & (op_arith | op_rot);

   wire logic ram_we = acc_wr & ~tgt_special & ~ind_self;
   wire logic flag_wr = acc_wr & tgt_flags & ~ind_self;
   wire logic ptr_wr = acc_wr & tgt_pointer & ~ind_self;
   // Any flag-owning instruction blocks the data write to all three low flags.
   wire logic own_flags = upd_z | upd_dc | upd_c;
   wire logic low_wr = flag_wr & ~own_flags;

   csa_file_ram #(
      .AW(RAW)
   ) u_ram (
      .clk(clk),
      .we(ram_we),
      .waddr(eff_addr[RAW-1:0]),
      .wdata(wr_data),
      .raddr(eff_addr[RAW-1:0]),
      .rdata(ram_rdata)
   );

   // Next flag values; instruction results win over the data write.
   wire logic z_next = upd_z ? (alu_res == 8'h00) :
                       low_wr ? wr_data[`CSA_BIT_ZERO] : flags_reg[`CSA_BIT_ZERO];
   wire logic dc_next = upd_dc ? alu_dc :
                        low_wr ? wr_data[`CSA_BIT_NIBBLE] : flags_reg[`CSA_BIT_NIBBLE];
   wire logic c_next = upd_c ? alu_c :
                       low_wr ? wr_data[`CSA_BIT_CARRY] : flags_reg[`CSA_BIT_CARRY];
   wire logic wake_next = flag_wr ? wr_data[`CSA_BIT_WAKE] : flags_reg[`CSA_BIT_WAKE];
   wire logic page_next = flag_wr ? wr_data[`CSA_BIT_PAGE] : flags_reg[`CSA_BIT_PAGE];
   // Only watchdog and sleep events move these two bits; the set wins.
   wire logic exp_next = (wdt_kick | sleep_op) ? 1'b1 :
                         wdt_timeout ? 1'b0 : flags_reg[`CSA_BIT_EXPIRY];
   wire logic slp_next = wdt_kick ? 1'b1 :
                         sleep_op ? 1'b0 : flags_reg[`CSA_BIT_SLEEP];
   // A clear aimed here gives 000u u1uu through the paths above.
   assign flags_next = {wake_next, 1'b0, page_next, exp_next,
                        slp_next, z_next, dc_next, c_next};
   assign pointer_next = ptr_wr ? {LARGE & wr_data[5], wr_data[4:0]} : pointer_reg;

   // Program counter with the page bit and wrap to implemented words.
   wire logic [`CSA_PC_WIDTH-1:0] pc_jump = {2'b00, flags_reg[`CSA_BIT_PAGE],
                                             core_req.pc_target};
   wire logic [`CSA_PC_WIDTH-1:0] pc_raw = (sel_core & core_req.pc_load) ? pc_jump :
                                           (sel_core & core_req.pc_inc) ? pc_reg + 12'h001 :
                                           pc_reg;
   assign pc_next = pc_raw & PC_MASK;

   // Bus readback, with the full counter at its own word.
   assign ahb_value = (ahb_idx == `CSA_IDX_PC_FULL) ? {20'h0_0000, pc_reg} :
                      ahb_idx[5] ? 32'h0000_0000 : {24'h00_0000, file_rd};

   always_ff @(posedge clk) begin
      if (reset) begin
         flags_reg <= {wake_cause, 7'h00} | `CSA_FLAGS_RESET;
         pointer_reg <= `CSA_POINTER_RESET;
         pc_reg <= `CSA_RESET_VECTOR;
         result_reg <= 8'h00;
         file_value_reg <= 8'h00;
      end else begin
         flags_reg <= flags_next;
         pointer_reg <= pointer_next;
         pc_reg <= pc_next;
         if (sel_core) begin
            result_reg <= alu_res;
            file_value_reg <= file_rd;
         end
      end
   end

   assign core_resp = '{result: result_reg, file_value: file_value_reg, flags: flags_reg};
   assign program_counter = pc_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_pc_wrap: assert property ((program_counter & ~PC_MASK) == 12'h000)
      else $error("Program counter outside implemented memory.");
   chk_reset_vector: assert property ($past(reset) |-> program_counter == 12'h000)
      else $error("Program counter not at reset vector.");
   chk_flag_override: assert property (
      sel_core && core_req.write && tgt_flags && !ind_self && op_arith
      |=> flags_reg[1:0] == {$past(alu_dc), $past(alu_c)})
      else $error("Data write reached an owned flag.");
   chk_protect_bits: assert property (
      flag_wr && !wdt_kick && !sleep_op && !wdt_timeout
      |=> flags_reg[4:3] == $past(flags_reg[4:3]))
      else $error("Protected flag changed by a write.");
   chk_sleep_entry: assert property (sleep_op && !wdt_kick |=> flags_reg[4:3] == 2'b10)
      else $error("Sleep did not set expiry and clear sleep flag.");
   chk_timeout_clr: assert property (
      wdt_timeout && !wdt_kick && !sleep_op |=> !flags_reg[`CSA_BIT_EXPIRY])
      else $error("Timeout did not clear expiry flag.");
   chk_clear_keep: assert property (
      sel_core && core_req.write && tgt_flags && !ind_self && core_req.op == CSA_OP_LOGIC
      |=> flags_reg[1:0] == $past(flags_reg[1:0]))
      else $error("Clear of flags register changed carry flags.");
   chk_unimpl_bit: assert property (flags_reg[6] == 1'b0)
      else $error("Unimplemented flag bit set.");
   chk_zero_flag: assert property (upd_z |=> flags_reg[2] == ($past(alu_res) == 8'h00))
      else $error("Zero flag does not follow result.");
   chk_null_read: assert property (sel_core && ind_self |=> core_resp.file_value == 8'h00)
      else $error("Window read through zero pointer not zero.");
   chk_self_write: assert property (ind_self |-> !ram_we && !flag_wr && !ptr_wr)
      else $error("Write through window onto itself stored data.");
   chk_pointer_ones: assert property (
      LARGE ? pointer_view[7:6] == 2'b11 : pointer_view[7:5] == 3'b111)
      else $error("Unimplemented pointer bits not read as ones.");

   cov_ind_access: cover property (sel_core && is_ind && !ind_self);
   cov_bus_flag_write: cover property (flag_wr && !sel_core);
   cov_sleep_entry: cover property (sleep_op);
   cov_pc_wrap: cover property (pc_reg == PC_MASK && sel_core && core_req.pc_inc);
endmodule : csa_core_status
`default_nettype wire

// ---- csa_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module csa_core_model
   import csa_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Request towards the status block.
   output var csa_core_req_t core_req
);
   initial begin
      core_req = '0;
   end
   // The model has no path that writes program memory.
   // Callers write core_flags as the target file only with move, logic or add steps.
   // One instruction step, held for exactly one sampling edge.
   task automatic step(input csa_alu_op_t op, input logic wr, input logic [4:0] fsel,
                       input logic [7:0] operand, input logic [7:0] wdata,
                       input logic inc, input logic ld, input logic [8:0] target);
      @(posedge clk);
      core_req <= '{1'b1, wr, fsel, op, operand, wdata, inc, ld, target};
      @(posedge clk);
      core_req.valid <= 1'b0;
      #1;
   endtask : step
endmodule : csa_core_model
`default_nettype wire

// ---- test_core_status_and_addressing.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_core_status_and_addressing;
   import csa_pkg::*;
   typedef struct packed {
      csa_alu_op_t op;
      logic [4:0] fsel;
      logic [7:0] operand;
      logic [7:0] wdata;
      logic [7:0] res;
      logic [7:0] flags;
   } csa_row_t;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic wake_cause = 1'b0;
   logic wdt_kick = 1'b0;
   logic sleep_op = 1'b0;
   logic wdt_timeout = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   wire logic hreadyout;
   wire logic [31:0] hrdata;
   wire logic hresp;
   csa_core_req_t core_req;
   csa_core_resp_t core_resp;
   logic [11:0] program_counter;
   logic [31:0] rd;
   int fail_count = 0;
   int check_count = 0;
   csa_row_t rows [11];
   always #5 clk = ~clk;
   csa_core_status #(.LARGE(1'b0)) i_csa_core_status (.clk(clk), .reset(reset),
      .core_req(core_req), .core_resp(core_resp), .program_counter(program_counter),
      .wake_cause(wake_cause), .wdt_kick(wdt_kick), .sleep_op(sleep_op),
      .wdt_timeout(wdt_timeout), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
   csa_core_model i_csa_core_model (.clk(clk), .core_req(core_req));
   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Waits for hready sampled high at a rising edge, bounded.
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         $display("Error hready expected 1 seen %b", hreadyout);
         test_done();
      end
   endtask : wait_ready
   // One single word transfer; read data lands in rd.
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= data;
      wait_ready();
      rd = hrdata;
      hwrite <= 1'b0;
   endtask : bus
   task automatic pulse(input int which);
      @(posedge clk);
      wdt_timeout <= (which == 0);
      sleep_op <= (which == 1);
      wdt_kick <= (which == 2);
      @(posedge clk);
      {wdt_timeout, sleep_op, wdt_kick} <= 3'h0;
      #1;
   endtask : pulse
   initial begin
      rows = '{'{CSA_OP_MOVE, 5'h05, 8'h00, 8'h0f, 8'h0f, 8'h18},
               '{CSA_OP_ADD, 5'h05, 8'h01, 8'h00, 8'h10, 8'h1a},
               '{CSA_OP_ADD, 5'h05, 8'hf0, 8'h00, 8'h00, 8'h1d},
               '{CSA_OP_SUB, 5'h05, 8'h01, 8'h00, 8'hff, 8'h18},
               '{CSA_OP_RRF, 5'h05, 8'h00, 8'h00, 8'h7f, 8'h19},
               '{CSA_OP_RLF, 5'h05, 8'h00, 8'h00, 8'hff, 8'h18},
               '{CSA_OP_SUB, 5'h05, 8'h0f, 8'h00, 8'hf0, 8'h1b},
               '{CSA_OP_LOGIC, 5'h05, 8'h00, 8'h00, 8'h00, 8'h1f},
               '{CSA_OP_MOVE, 5'h03, 8'h00, 8'ha3, 8'ha3, 8'hbb},
               '{CSA_OP_LOGIC, 5'h03, 8'h00, 8'h00, 8'h00, 8'h1f},
               '{CSA_OP_ADD, 5'h03, 8'he4, 8'h00, 8'h03, 8'h1b}};
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      chk("pc_reset", 32'h0, {20'h0, program_counter});
      bus(1'b0, 32'h0c, 32'h0);
      chk("flags_reset", 32'h18, rd);
      bus(1'b0, 32'h10, 32'h0);
      chk("pointer_reset", 32'he0, rd);
      bus(1'b0, 32'h80, 32'h0);
      chk("pc_full", 32'h0, rd);
      foreach (rows[i]) begin
         i_csa_core_model.step(rows[i].op, 1'b1, rows[i].fsel, rows[i].operand,
                               rows[i].wdata, 1'b0, 1'b0, 9'h0);
         chk("row_result", {24'h0, rows[i].res}, {24'h0, core_resp.result});
         chk("row_flags", {24'h0, rows[i].flags}, {24'h0, core_resp.flags});
      end
      i_csa_core_model.step(CSA_OP_MOVE, 1'b0, 5'h00, 8'h00, 8'h00, 1'b0, 1'b1, 9'h1ff);
      chk("pc_load", 32'h1ff, {20'h0, program_counter});
      i_csa_core_model.step(CSA_OP_MOVE, 1'b0, 5'h00, 8'h00, 8'h00, 1'b1, 1'b0, 9'h0);
      chk("pc_wrap", 32'h0, {20'h0, program_counter});
      i_csa_core_model.step(CSA_OP_MOVE, 1'b1, 5'h03, 8'h00, 8'h20, 1'b0, 1'b0, 9'h0);
      chk("page_bit", 32'h38, {24'h0, core_resp.flags});
      i_csa_core_model.step(CSA_OP_MOVE, 1'b0, 5'h00, 8'h00, 8'h00, 1'b0, 1'b1, 9'h005);
      chk("pc_page_fold", 32'h005, {20'h0, program_counter});
      pulse(0);
      chk("timeout_bits", 32'h1, {30'h0, core_resp.flags[4:3]});
      pulse(1);
      chk("sleep_bits", 32'h2, {30'h0, core_resp.flags[4:3]});
      pulse(2);
      chk("kick_bits", 32'h3, {30'h0, core_resp.flags[4:3]});
      i_csa_core_model.step(CSA_OP_MOVE, 1'b1, 5'h07, 8'h00, 8'h5a, 1'b0, 1'b0, 9'h0);
      bus(1'b1, 32'h10, 32'h27);
      bus(1'b0, 32'h10, 32'h0);
      chk("pointer_bits", 32'he7, rd);
      bus(1'b0, 32'h00, 32'h0);
      chk("window_direct", 32'h5a, rd);
      bus(1'b1, 32'h00, 32'ha5);
      bus(1'b0, 32'h1c, 32'h0);
      chk("window_write", 32'ha5, rd);
      bus(1'b1, 32'h10, 32'h00);
      bus(1'b1, 32'h00, 32'h33);
      bus(1'b0, 32'h00, 32'h0);
      chk("window_self", 32'h0, rd);
      @(posedge clk);
      reset <= 1'b1;
      wake_cause <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      wake_cause <= 1'b0;
      chk("pc_rereset", 32'h0, {20'h0, program_counter});
      bus(1'b0, 32'h0c, 32'h0);
      chk("flags_wake", 32'h98, rd);
      bus(1'b0, 32'h1c, 32'h0);
      chk("file_kept", 32'ha5, rd);
      bus(1'b0, 32'h100, 32'h0);
      chk("unmapped", 32'h0, rd);
      test_done();
   end
endmodule : test_core_status_and_addressing
`default_nettype wire
